// *** shared/pllctl_pkg.sv ***
package pllctl_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CSR = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_PREDIV = 8'h08;
  localparam logic [7:0] OFS_POST1 = 8'h0C;
  localparam logic [7:0] OFS_POST2 = 8'h10;
  localparam logic [7:0] OFS_POST3 = 8'h14;
  localparam logic [7:0] OFS_OSCDIV = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;

  // Control/status field positions and reset values
  localparam int CSR_STABLE_BIT = 6;
  localparam int CSR_LRST_BIT = 3;
  localparam int CSR_PWRDN_BIT = 1;
  localparam int CSR_PLLEN_BIT = 0;
  localparam logic PLLEN_RST = 1'b0;
  localparam logic LRST_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b0;

  // Multiplier and divider fields
  localparam int MULT_W = 5;
  localparam logic [MULT_W-1:0] MULT_RST = 5'h00;
  localparam int RATIO_W = 5;
  localparam int DIV_EN_BIT = 15;

  typedef struct packed {
    logic en;
    logic [RATIO_W-1:0] ratio;
  } pllctl_div_t;

  // Divider slots: programmable ones first, fixed divide-by-8 last
  localparam int DIV_OSC = 0;
  localparam int DIV_PRE = 1;
  localparam int DIV_POST1 = 2;
  localparam int DIV_POST2 = 3;
  localparam int DIV_POST3 = 4;
  localparam int DIV_FIX = 5;
  localparam int NUM_CFG = 5;
  localparam int NUM_DIV = 6;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [RATIO_W-1:0] FIXED_RATIO = 5'h07;
  localparam pllctl_div_t DIV_RST [NUM_CFG] = '{
    '{en: 1'b1, ratio: 5'h07},
    '{en: 1'b1, ratio: 5'h00},
    '{en: 1'b1, ratio: 5'h00},
    '{en: 1'b1, ratio: 5'h01},
    '{en: 1'b1, ratio: 5'h03}
  };

  // Stabilisation counts in reference rising edges
  localparam int STABLE_EXT_CYCLES = 512;
  localparam int STABLE_OSC_CYCLES = 4096;
  localparam int STABLE_CNT_W = 13;

  // Multiplier period meter width
  localparam int HALF_W = 16;

  // Interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_STABLE_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;

  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN = 3'b100
  } pllctl_rst_state_t;

endpackage

// *** shared/pllctl_div_if.sv ***
`timescale 1ns/1ps
interface pllctl_div_if;
  logic in_clk;
  logic enable;
  logic [pllctl_pkg::RATIO_W-1:0] ratio;
  logic out_clk;
  modport ctl (output in_clk, output enable, output ratio, input out_clk);
  modport div (input in_clk, input enable, input ratio, output out_clk);
endinterface

// *** hw/pllctl_divider.sv ***
`timescale 1ns/1ps
module pllctl_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Divider link
  pllctl_div_if.div dv
);

  logic prev_r;
  logic in_toggle;
  logic [pllctl_pkg::RATIO_W-1:0] cnt_r;
  logic out_r;

  assign in_toggle = dv.in_clk != prev_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= dv.in_clk;
    end
  end

  // Counting both input edges gives 50% duty for odd ratios too
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
      out_r <= 1'b0;
    end else if (!dv.enable) begin
      cnt_r <= 5'h00;
      out_r <= 1'b0;
    end else if (in_toggle) begin
      // Greater-or-equal keeps a shrunk ratio from running away
      if (cnt_r >= dv.ratio) begin
        cnt_r <= 5'h00;
        out_r <= ~out_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign dv.out_clk = out_r;

endmodule // pllctl_divider

// *** hw/pllctl_top.sv ***
`timescale 1ns/1ps
// What this block does
// - Source pin selects external or oscillator reference
// - Multiplier register sets times one to thirty-two
// - Dividers span one to thirty-two, disabled gives nothing
// - Reference goes undivided to the auxiliary output
// - Enabled oscillator divider drives divided oscillator output
// - Path enable picks multiplied path or bypass
// - Pre-divided reference multiplied feeds the post-dividers
// - Post-dividers give fifty percent duty from an even input clock
// - Hold internal reset for 512 or 4096 edges
// - During internal reset all five clock outputs are reference/8
// - Count done releases reset, sets stable bit
// - After release dividers run at default ratios
// - Capture initial values at external reset release
// - Status layout: stable 6, reset 3, powerdown 1, enable 0
// - Multiplier field bits 4 to 0, rest zero
module pllctl_top #(
  parameter int STABLE_EXT_COUNT = pllctl_pkg::STABLE_EXT_CYCLES,
  parameter int STABLE_OSC_COUNT = pllctl_pkg::STABLE_OSC_CYCLES
) (
  // Clock and external reset
  input wire logic clock,
  input wire logic rst,
  // Reference inputs
  input wire logic clock_source_select_pin,
  input wire logic external_ref_clock,
  input wire logic oscillator_ref_clock,
  // Register port
  input wire logic [pllctl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pllctl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [pllctl_pkg::DATA_W-1:0] reg_rdata,
  // Generated clocks
  output logic auxiliary_clock_out,
  output logic divided_osc_clock_out,
  output logic system_clock_one,
  output logic system_clock_two,
  output logic system_clock_three,
  // Reset and interrupt
  output logic internal_reset_n,
  output logic irq
);

  localparam int CW = pllctl_pkg::STABLE_CNT_W;
  localparam int HW1 = pllctl_pkg::HALF_W + 1;
  localparam logic [CW-1:0] EXT_LAST = CW'(STABLE_EXT_COUNT - 1);
  localparam logic [CW-1:0] OSC_LAST = CW'(STABLE_OSC_COUNT - 1);

  function automatic logic [2:0] div_slot(input logic [pllctl_pkg::ADDR_W-1:0] a);
    case (a)
      pllctl_pkg::OFS_OSCDIV: div_slot = 3'h0;
      pllctl_pkg::OFS_PREDIV: div_slot = 3'h1;
      pllctl_pkg::OFS_POST1: div_slot = 3'h2;
      pllctl_pkg::OFS_POST2: div_slot = 3'h3;
      pllctl_pkg::OFS_POST3: div_slot = 3'h4;
      default: div_slot = pllctl_pkg::SLOT_NONE;
    endcase
  endfunction

  function automatic logic [pllctl_pkg::DATA_W-1:0] div_word(input pllctl_pkg::pllctl_div_t d);
    logic [pllctl_pkg::DATA_W-1:0] w;
    w = 32'h0000_0000;
    w[pllctl_pkg::DIV_EN_BIT] = d.en;
    w[pllctl_pkg::RATIO_W-1:0] = d.ratio;
    return w;
  endfunction

  pllctl_pkg::pllctl_rst_state_t state_r;
  logic src_r;
  logic src_sel;
  logic ref_lvl;
  logic ref_prev_r;
  logic ref_rise;
  logic [CW-1:0] stab_cnt_r;
  logic stable_r;
  logic int_rst_n_r;
  logic stable_evt;

  logic pll_en_r;
  logic loop_rst_r;
  logic pwrdn_r;
  logic [pllctl_pkg::MULT_W-1:0] mult_r;
  pllctl_pkg::pllctl_div_t cfg_r [pllctl_pkg::NUM_CFG];
  logic [2:0] wslot;
  logic [2:0] rslot;
  logic csr_wr;
  logic mode_evt;

  logic [pllctl_pkg::IRQ_W-1:0] irq_stat_r;
  logic [pllctl_pkg::IRQ_W-1:0] irq_en_r;
  logic [pllctl_pkg::IRQ_W-1:0] irq_set;
  logic [pllctl_pkg::IRQ_W-1:0] irq_clr;
  logic [pllctl_pkg::DATA_W-1:0] rdata_r;

  logic div_in [pllctl_pkg::NUM_DIV];
  logic div_en [pllctl_pkg::NUM_DIV];
  logic [pllctl_pkg::RATIO_W-1:0] div_ratio [pllctl_pkg::NUM_DIV];
  logic div_out [pllctl_pkg::NUM_DIV];

  logic mult_in;
  logic mult_prev_r;
  logic mult_run;
  logic [pllctl_pkg::HALF_W-1:0] hcnt_r;
  logic [pllctl_pkg::HALF_W-1:0] half_r;
  logic [HW1-1:0] acc_r;
  logic [HW1-1:0] acc_sum;
  logic [HW1-1:0] mult_fac;
  logic mult_clk_r;

  logic aux_r;
  logic oscdiv_r;
  logic sys1_r;
  logic sys2_r;
  logic sys3_r;
  logic irq_r;

  // Reference selection and edge detection
  // The pin is live only in the strap cycle, then the captured copy rules
  assign src_sel = (state_r == pllctl_pkg::ST_STRAP) ? clock_source_select_pin : src_r;
  assign ref_lvl = src_sel ? external_ref_clock : oscillator_ref_clock;
  assign ref_rise = ref_lvl && !ref_prev_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_lvl;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_r <= 1'b0;
    end else if (state_r == pllctl_pkg::ST_STRAP) begin
      src_r <= clock_source_select_pin;
    end
  end

  // Reset lengthening
  assign stable_evt = (state_r == pllctl_pkg::ST_COUNT) && ref_rise &&
                      (stab_cnt_r == (src_r ? EXT_LAST : OSC_LAST));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= pllctl_pkg::ST_STRAP;
      stab_cnt_r <= 13'h0000;
      stable_r <= 1'b0;
      int_rst_n_r <= 1'b0;
    end else begin
      case (state_r)
        pllctl_pkg::ST_STRAP: begin
          state_r <= pllctl_pkg::ST_COUNT;
        end
        pllctl_pkg::ST_COUNT: begin
          if (stable_evt) begin
            state_r <= pllctl_pkg::ST_RUN;
            stable_r <= 1'b1;
            int_rst_n_r <= 1'b1;
          end else if (ref_rise) begin
            stab_cnt_r <= stab_cnt_r + 1'b1;
          end
        end
        pllctl_pkg::ST_RUN: begin
          state_r <= pllctl_pkg::ST_RUN;
        end
        default: begin
          state_r <= pllctl_pkg::ST_STRAP;
        end
      endcase
    end
  end

  // Register writes
  assign csr_wr = reg_write && (reg_addr == pllctl_pkg::OFS_CSR);
  assign mode_evt = csr_wr && (reg_wdata[pllctl_pkg::CSR_PLLEN_BIT] != pll_en_r);
  assign wslot = reg_write ? div_slot(reg_addr) : pllctl_pkg::SLOT_NONE;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pll_en_r <= pllctl_pkg::PLLEN_RST;
      loop_rst_r <= pllctl_pkg::LRST_RST;
      pwrdn_r <= pllctl_pkg::PWRDN_RST;
    end else if (csr_wr) begin
      pll_en_r <= reg_wdata[pllctl_pkg::CSR_PLLEN_BIT];
      loop_rst_r <= reg_wdata[pllctl_pkg::CSR_LRST_BIT];
      pwrdn_r <= reg_wdata[pllctl_pkg::CSR_PWRDN_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mult_r <= pllctl_pkg::MULT_RST;
    end else if (reg_write && (reg_addr == pllctl_pkg::OFS_MULT)) begin
      mult_r <= reg_wdata[pllctl_pkg::MULT_W-1:0];
    end
  end

  // Defaults stay in force until software rewrites a slot
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pllctl_pkg::NUM_CFG; i++) begin
        cfg_r[i] <= pllctl_pkg::DIV_RST[i];
      end
    end else if (wslot != pllctl_pkg::SLOT_NONE) begin
      cfg_r[wslot].en <= reg_wdata[pllctl_pkg::DIV_EN_BIT];
      cfg_r[wslot].ratio <= reg_wdata[pllctl_pkg::RATIO_W-1:0];
    end
  end

  // Interrupts: a set in the clearing cycle survives
  assign irq_set = {mode_evt, stable_evt};
  assign irq_clr = (reg_write && (reg_addr == pllctl_pkg::OFS_IRQ_CLR)) ?
                   reg_wdata[pllctl_pkg::IRQ_W-1:0] : 2'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
      irq_en_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (reg_write && (reg_addr == pllctl_pkg::OFS_IRQ_EN)) begin
        irq_en_r <= reg_wdata[pllctl_pkg::IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // Register reads, data valid in the following cycle only
  assign rslot = div_slot(reg_addr);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (reg_read) begin
        if (rslot != pllctl_pkg::SLOT_NONE) begin
          rdata_r <= div_word(cfg_r[rslot]);
        end else begin
          case (reg_addr)
            pllctl_pkg::OFS_CSR: begin
              rdata_r[pllctl_pkg::CSR_STABLE_BIT] <= stable_r;
              rdata_r[pllctl_pkg::CSR_LRST_BIT] <= loop_rst_r;
              rdata_r[pllctl_pkg::CSR_PWRDN_BIT] <= pwrdn_r;
              rdata_r[pllctl_pkg::CSR_PLLEN_BIT] <= pll_en_r;
            end
            pllctl_pkg::OFS_MULT: begin
              rdata_r[pllctl_pkg::MULT_W-1:0] <= mult_r;
            end
            pllctl_pkg::OFS_IRQ_STAT: begin
              rdata_r[pllctl_pkg::IRQ_W-1:0] <= irq_stat_r;
            end
            pllctl_pkg::OFS_IRQ_EN: begin
              rdata_r[pllctl_pkg::IRQ_W-1:0] <= irq_en_r;
            end
            default: begin
              rdata_r <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  // Divider routing
  always_comb begin
    for (int i = 0; i < pllctl_pkg::NUM_CFG; i++) begin
      div_en[i] = cfg_r[i].en;
      div_ratio[i] = cfg_r[i].ratio;
    end
    div_in[pllctl_pkg::DIV_OSC] = ref_lvl;
    div_in[pllctl_pkg::DIV_PRE] = ref_lvl;
    div_en[pllctl_pkg::DIV_PRE] = cfg_r[pllctl_pkg::DIV_PRE].en && pll_en_r;
    div_in[pllctl_pkg::DIV_POST1] = pll_en_r ? mult_clk_r : ref_lvl;
    div_in[pllctl_pkg::DIV_POST2] = pll_en_r ? mult_clk_r : ref_lvl;
    div_in[pllctl_pkg::DIV_POST3] = pll_en_r ? mult_clk_r : ref_lvl;
    div_in[pllctl_pkg::DIV_FIX] = ref_lvl;
    div_en[pllctl_pkg::DIV_FIX] = 1'b1;
    div_ratio[pllctl_pkg::DIV_FIX] = pllctl_pkg::FIXED_RATIO;
  end

  pllctl_div_if dv [pllctl_pkg::NUM_DIV] ();

  for (genvar g = 0; g < pllctl_pkg::NUM_DIV; g++) begin : g_div
    assign dv[g].in_clk = div_in[g];
    assign dv[g].enable = div_en[g];
    assign dv[g].ratio = div_ratio[g];
    assign div_out[g] = dv[g].out_clk;
    pllctl_divider u_div (
      .clock(clock),
      .rst(rst),
      .dv(dv[g])
    );
  end

  // Multiplier model: measures the input half period in system cycles and
  // toggles M times per half period; output can never exceed half the
  // system clock, so high products saturate
  assign mult_in = div_out[pllctl_pkg::DIV_PRE];
  assign mult_run = pll_en_r && !loop_rst_r && !pwrdn_r;
  assign mult_fac = HW1'(mult_r) + HW1'(1);
  assign acc_sum = acc_r + mult_fac;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mult_prev_r <= 1'b0;
      hcnt_r <= 16'h0000;
      half_r <= 16'h0000;
    end else begin
      mult_prev_r <= mult_in;
      if (mult_in != mult_prev_r) begin
        half_r <= hcnt_r + 1'b1;
        hcnt_r <= 16'h0000;
      end else if (hcnt_r != 16'hFFFF) begin
        hcnt_r <= hcnt_r + 1'b1;
      end
    end
  end

  // A stalled or disabled input silences the multiplied clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_r <= 17'h0_0000;
      mult_clk_r <= 1'b0;
    end else if (!mult_run || (half_r == 16'h0000) || (hcnt_r == 16'hFFFF)) begin
      acc_r <= 17'h0_0000;
      mult_clk_r <= 1'b0;
    end else if (acc_sum >= {1'b0, half_r}) begin
      acc_r <= acc_sum - {1'b0, half_r};
      mult_clk_r <= ~mult_clk_r;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // Output stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux_r <= 1'b0;
      oscdiv_r <= 1'b0;
      sys1_r <= 1'b0;
      sys2_r <= 1'b0;
      sys3_r <= 1'b0;
    end else if (!int_rst_n_r) begin
      aux_r <= div_out[pllctl_pkg::DIV_FIX];
      oscdiv_r <= div_out[pllctl_pkg::DIV_FIX];
      sys1_r <= div_out[pllctl_pkg::DIV_FIX];
      sys2_r <= div_out[pllctl_pkg::DIV_FIX];
      sys3_r <= div_out[pllctl_pkg::DIV_FIX];
    end else begin
      aux_r <= ref_lvl;
      oscdiv_r <= div_out[pllctl_pkg::DIV_OSC];
      sys1_r <= div_out[pllctl_pkg::DIV_POST1];
      sys2_r <= div_out[pllctl_pkg::DIV_POST2];
      sys3_r <= div_out[pllctl_pkg::DIV_POST3];
    end
  end

  assign auxiliary_clock_out = aux_r;
  assign divided_osc_clock_out = oscdiv_r;
  assign system_clock_one = sys1_r;
  assign system_clock_two = sys2_r;
  assign system_clock_three = sys3_r;
  assign internal_reset_n = int_rst_n_r;
  assign irq = irq_r;
  assign reg_rdata = rdata_r;

endmodule // pllctl_top

// *** sim/pllctl_ref_src.sv ***
`timescale 1ns/1ps
module pllctl_ref_src #(
  parameter int HALF_EXT = 4,
  parameter int HALF_OSC = 3
) (
  // Clock
  input wire logic clock,
  // References
  output logic external_ref_clock,
  output logic oscillator_ref_clock
);
  // Both sources run free and move just after the system edge, so levels last whole cycles
  int ext_cnt;
  int osc_cnt;
  initial begin
    external_ref_clock = 1'b0;
    oscillator_ref_clock = 1'b0;
    ext_cnt = 0;
    osc_cnt = 0;
  end
  always @(posedge clock) begin
    ext_cnt <= (ext_cnt == HALF_EXT - 1) ? 0 : ext_cnt + 1;
    osc_cnt <= (osc_cnt == HALF_OSC - 1) ? 0 : osc_cnt + 1;
    if (ext_cnt == HALF_EXT - 1) external_ref_clock <= ~external_ref_clock;
    if (osc_cnt == HALF_OSC - 1) oscillator_ref_clock <= ~oscillator_ref_clock;
  end
endmodule // pllctl_ref_src

// *** sim/pllctl_props.sv ***
`timescale 1ns/1ps
module pllctl_props #(
  parameter int STABLE_EXT_COUNT = 512,
  parameter int STABLE_OSC_COUNT = 4096
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // References
  input wire logic clock_source_select_pin,
  input wire logic external_ref_clock,
  input wire logic oscillator_ref_clock,
  // Register port
  input wire logic [pllctl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pllctl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [pllctl_pkg::DATA_W-1:0] reg_rdata,
  // Outputs
  input wire logic auxiliary_clock_out,
  input wire logic divided_osc_clock_out,
  input wire logic system_clock_one,
  input wire logic system_clock_two,
  input wire logic system_clock_three,
  input wire logic internal_reset_n,
  input wire logic irq
);
  logic strap_r;
  logic src_r;
  logic ref_q_r;
  int edges_r;
  logic ref_sel;
  int need;
  logic src_now;
  // Outputs are only defined once an edge has seen reset high
  logic armed_r = 1'b0;
  always @(posedge clock) armed_r <= 1'b1;
  // The pin picks the source in the strap cycle, so the edge count is exact
  assign src_now = strap_r ? clock_source_select_pin : src_r;
  assign ref_sel = src_now ? external_ref_clock : oscillator_ref_clock;
  assign need = src_r ? STABLE_EXT_COUNT : STABLE_OSC_COUNT;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_r <= 1'b1;
      src_r <= 1'b0;
      ref_q_r <= 1'b0;
      edges_r <= 0;
    end else begin
      strap_r <= 1'b0;
      ref_q_r <= ref_sel;
      if (strap_r) src_r <= clock_source_select_pin;
      if (!strap_r && ref_sel && !ref_q_r) edges_r <= edges_r + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_quiet_in_reset: assert property (disable iff (1'b0) armed_r && rst
    |-> !internal_reset_n && !irq && !system_clock_one && !auxiliary_clock_out
    && !divided_osc_clock_out && !system_clock_two && !system_clock_three && reg_rdata == '0)
    else $error("outputs not quiet");
  a_hold_after_rst: assert property ($fell(rst) |-> !internal_reset_n [*8])
    else $error("internal reset released too soon");
  a_release_not_early: assert property (internal_reset_n |-> edges_r >= need)
    else $error("internal reset released early");
  a_release_not_late: assert property (!internal_reset_n && !strap_r |-> edges_r < need)
    else $error("internal reset released late");
  a_aux_tracks_ref: assert property (internal_reset_n && $past(internal_reset_n, 2)
    |-> auxiliary_clock_out == $past(ref_sel)) else $error("aux clock not the reference");
  a_csr_reserved_zero: assert property ($past(reg_read && reg_addr == pllctl_pkg::OFS_CSR)
    |-> reg_rdata[31:7] == '0 && reg_rdata[5:4] == '0 && !reg_rdata[2]) else $error("csr reserved");
  a_stable_matches_release: assert property ($past(reg_read && reg_addr == pllctl_pkg::OFS_CSR)
    |-> reg_rdata[6] == $past(internal_reset_n)) else $error("stable bit mismatch");
  a_mult_upper_zero: assert property ($past(reg_read && reg_addr == pllctl_pkg::OFS_MULT)
    |-> reg_rdata[31:5] == '0) else $error("multiplier upper bits set");
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  c_release: cover property ($rose(internal_reset_n));
  c_pll_on: cover property (reg_write && reg_addr == pllctl_pkg::OFS_CSR && reg_wdata[0]);
  c_irq: cover property ($rose(irq));
endmodule // pllctl_props
bind pllctl_top pllctl_props #(.STABLE_EXT_COUNT(STABLE_EXT_COUNT),
  .STABLE_OSC_COUNT(STABLE_OSC_COUNT)) u_props (.clock(clock), .rst(rst),
  .clock_source_select_pin(clock_source_select_pin), .external_ref_clock(external_ref_clock),
  .oscillator_ref_clock(oscillator_ref_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .auxiliary_clock_out(auxiliary_clock_out), .divided_osc_clock_out(divided_osc_clock_out),
  .system_clock_one(system_clock_one), .system_clock_two(system_clock_two),
  .system_clock_three(system_clock_three), .internal_reset_n(internal_reset_n), .irq(irq));

// *** sim/pllctl_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module pllctl_top_tb;
  localparam int EXT_N = 16;
  localparam int OSC_N = 32;
  localparam int HE = 4;
  localparam int HO = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic src_pin = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic ext_ref, osc_ref, aux, dosc, s1, s2, s3, irn, irq, acc;
  logic [31:0] d;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 48;
  int cyc = 0;
  int t0, h1, h2, n, f;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28};
  logic [31:0] rv [10] = '{32'h0000_0048, 32'h0000_0000, 32'h0000_8000, 32'h0000_8000,
    32'h0000_8001, 32'h0000_8003, 32'h0000_8007, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] da [4] = '{8'h18, 8'h0C, 8'h10, 8'h14};
  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  pllctl_ref_src #(.HALF_EXT(HE), .HALF_OSC(HO)) ref_src (.clock(clock),
    .external_ref_clock(ext_ref), .oscillator_ref_clock(osc_ref));
  pllctl_top #(.STABLE_EXT_COUNT(EXT_N), .STABLE_OSC_COUNT(OSC_N)) DUT (.clock(clock), .rst(rst),
    .clock_source_select_pin(src_pin), .external_ref_clock(ext_ref), .oscillator_ref_clock(osc_ref),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .auxiliary_clock_out(aux), .divided_osc_clock_out(dosc),
    .system_clock_one(s1), .system_clock_two(s2), .system_clock_three(s3),
    .internal_reset_n(irn), .irq(irq));
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic timed_out(input int c);
    if (c > 5000) begin
      err_count++;
      $display("[FAIL] wait expected event seen none");
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic logic pick(input int i);
    case (i)
      0: return dosc;
      1: return s1;
      2: return s2;
      3: return s3;
      default: return aux;
    endcase
  endfunction
  // Cycles until the chosen output next changes, sampled after the edge settles
  task automatic wait_tog(input int i, output int c);
    logic v;
    v = pick(i);
    c = 0;
    while (pick(i) === v) begin
      @(posedge clock);
      #1 c++;
      timed_out(c);
    end
  endtask
  task automatic wait_rel(input int lo, input int hi);
    n = 0;
    while (irn !== 1'b1) begin
      @(posedge clock);
      #1 n++;
      timed_out(n);
    end
    `CHK("reset length", 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1 t0 = cyc;
    wait_tog(1, h1);
    wait_tog(1, h1);
    `CHK("sys1 half in reset", 8 * HE, h1)
    `CHK("still in reset", 1'b0, irn)
    wait_rel(2 * HE * (EXT_N - 1), 2 * HE * (EXT_N + 1) + 4);
    wait_tog(4, h1);
    wait_tog(4, h1);
    wait_tog(4, h1);
    `CHK("aux half", HE, h1)
    $display("test release done");
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], d);
      `CHK("reg default", rv[i], d)
    end
    `CHK("irq masked", 1'b0, irq)
    wr(pllctl_pkg::OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge clock);
    #1 `CHK("irq raised", 1'b1, irq)
    wr(pllctl_pkg::OFS_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clock);
    #1 `CHK("irq cleared", 1'b0, irq)
    rd(pllctl_pkg::OFS_IRQ_STAT, d);
    `CHK("irq status", 32'h0000_0000, d)
    wr(pllctl_pkg::OFS_MULT, 32'hFFFF_FFE1);
    rd(pllctl_pkg::OFS_MULT, d);
    `CHK("mult field", 32'h0000_0001, d)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 31 : (i == 1) ? 0 : ($random(seed) & 31);
      wr(da[i], 32'h0000_8000 | 32'(f));
      wait_tog(i, h1);
      wait_tog(i, h1);
      wait_tog(i, h1);
      wait_tog(i, h2);
      `CHK("divider half", (f + 1) * HE, h1)
      `CHK("divider duty", h1, h2)
    end
    wr(8'h10, 32'h0000_0000);
    repeat (4) @(posedge clock);
    acc = 1'b0;
    repeat (200) begin
      @(posedge clock);
      #1 acc = acc | s2;
    end
    `CHK("disabled divider", 1'b0, acc)
    $display("test dividers done");
    wr(pllctl_pkg::OFS_CSR, 32'h0000_0001);
    repeat (64) @(posedge clock);
    #1 acc = s1;
    n = 0;
    repeat (64 * HE) begin
      @(posedge clock);
      #1 if (s1 !== acc) n++;
      acc = s1;
    end
    `CHK("pll toggles", 1'b1, (n >= 124) && (n <= 132))
    rd(pllctl_pkg::OFS_CSR, d);
    `CHK("csr pll mode", 32'h0000_0041, d)
    rd(pllctl_pkg::OFS_IRQ_STAT, d);
    `CHK("mode irq", 1'b1, d[1])
    wr(pllctl_pkg::OFS_CSR, 32'h0000_0003);
    repeat (4) @(posedge clock);
    #1 acc = s1;
    n = 0;
    repeat (100) begin
      @(posedge clock);
      #1 if (s1 !== acc) n++;
    end
    `CHK("powerdown silences", 0, n)
    rd(pllctl_pkg::OFS_CSR, d);
    `CHK("csr powerdown", 32'h0000_0043, d)
    $display("test pll done");
    @(posedge clock);
    rst <= 1'b1;
    src_pin <= 1'b0;
    #1 `CHK("reset immediate", 1'b0, irn)
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1 t0 = cyc;
    rd(pllctl_pkg::OFS_CSR, d);
    `CHK("csr after rst", 32'h0000_0008, d)
    wait_tog(4, h1);
    wait_tog(4, h1);
    `CHK("aux half in reset", 8 * HO, h1)
    wait_rel(2 * HO * (OSC_N - 1), 2 * HO * (OSC_N + 1) + 4);
    wait_tog(4, h1);
    wait_tog(4, h1);
    wait_tog(4, h1);
    `CHK("aux half osc", HO, h1)
    rd(pllctl_pkg::OFS_CSR, d);
    `CHK("csr stable", 32'h0000_0048, d)
    $display("test rerun done");
    report_and_stop();
  end
endmodule // pllctl_top_tb
